// *** src/ilc_top.v ***
// Functional notes
// - three independent detectors per framer: loop-up, loop-down and spare.
// - pattern length one to eight or sixteen bits; detection only in t1 mode.
// - sixteen-bit pattern joins both definition bytes, first byte sent first.
// - lengths one to eight compare only the first definition byte.
// - up/down length from length control; spare length from its own register.
// - framed or unframed codes found with bit error rates up to 1e-2.
// - both inserted and overwriting framing bits are tolerated.
// - writing a detector's first (most significant) definition byte restarts its integration.
// - detect bit sets after about 48 ms of valid code.
// - realtime bit plus latched set and latched clear bits per detector.
// - latched bits reach the framer interrupt only when the mask allows.
// - four framers, each at framer 1 byte address plus 800h times index.
// - latched bits clear on write of one; realtime bits ignore writes.
`include "ilc_defines.vh"

module ilc_top #(
    parameter [16:0] INTEG_BITS = `ILC_INTEG_MS * `ILC_LINE_KBPS
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // receive line, one lane per framer
    input wire [3:0] rx_data,
    input wire [3:0] rx_bit_strobe,
    input wire [3:0] t1_mode,
    // framer interrupt contributions, active high
    output reg [3:0] loop_code_irq
);

    integer i;

    // per-framer registers
    reg [7:0] inband_code_length_control [0:3];
    reg [7:0] spare_code_length_control [0:3];
    reg [7:0] up_code_definition_1 [0:3];
    reg [7:0] up_code_definition_2 [0:3];
    reg [7:0] down_code_definition_1 [0:3];
    reg [7:0] down_code_definition_2 [0:3];
    reg [7:0] spare_code_definition_1 [0:3];
    reg [7:0] spare_code_definition_2 [0:3];
    reg [7:0] loop_code_interrupt_mask [0:3];
    reg [7:0] loop_code_latched_status [0:3];
    reg [7:0] next_latched [0:3];

    // synchronised line inputs
    wire [3:0] rx_data_s;
    wire [3:0] rx_strobe_s;
    wire [3:0] t1_mode_s;
    reg [3:0] rx_strobe_q;
    reg [3:0] rx_data_q;
    wire [3:0] bit_valid;

    // detector status, index framer * 3 + detector (0 up, 1 down, 2 spare)
    wire [11:0] det_rt;
    wire [11:0] det_set;
    wire [11:0] det_clr;
    wire [11:0] det_restart;

    // address decode
    wire [1:0] sel_framer = paddr[12:11];
    wire [8:0] sel_index = paddr[10:2];
    wire addr_ok;
    wire wr_en;
    reg [7:0] rd_byte;

    // true for every register index this block maps
    function is_mapped;
        input [8:0] idx;
        begin
            case (idx)
                `ILC_IDX_LEN_CTL, `ILC_IDX_LATCHED, `ILC_IDX_SP_DEF1, `ILC_IDX_SP_DEF2,
                `ILC_IDX_SP_LEN, `ILC_IDX_MASK, `ILC_IDX_UP_DEF1, `ILC_IDX_UP_DEF2,
                `ILC_IDX_DN_DEF1, `ILC_IDX_DN_DEF2, `ILC_IDX_REALTIME: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // pin inputs cross into pclk before anything looks at them
    ilc_sync #(
        .W(12)
    ) u_sync (
        .clk(pclk),
        .rstn(presetn),
        .d({t1_mode, rx_bit_strobe, rx_data}),
        .q({t1_mode_s, rx_strobe_s, rx_data_s})
    );

    // bit strobe rising edge marks one received line bit; data held alongside
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_strobe_q <= 4'h0;
            rx_data_q <= 4'h0;
        end else begin
            rx_strobe_q <= rx_strobe_s;
            rx_data_q <= rx_data_s;
        end
    end

    assign bit_valid = rx_strobe_s & ~rx_strobe_q;

    // framer stride
    // framer select is index bits 10:9, i.e. a stride of 200h registers; word aligned addresses only
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[13] == 1'b0) && is_mapped(sel_index);
    assign wr_en = psel & penable & pwrite & addr_ok;

    // zero wait states: every access completes in its access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // twelve detectors: three per framer, each with its own bytes and length
    genvar f;
    generate
        for (f = 0; f < `ILC_FRAMERS; f = f + 1) begin : g_framer
            assign det_restart[3*f+0] = wr_en && (sel_framer == f) && (sel_index == `ILC_IDX_UP_DEF1);
            assign det_restart[3*f+1] = wr_en && (sel_framer == f) && (sel_index == `ILC_IDX_DN_DEF1);
            assign det_restart[3*f+2] = wr_en && (sel_framer == f) && (sel_index == `ILC_IDX_SP_DEF1);

            ilc_detector #(
                .INTEG_BITS(INTEG_BITS)
            ) u_up (
                .clk(pclk),
                .rstn(presetn),
                .enable(t1_mode_s[f]),
                .restart(det_restart[3*f+0]),
                .len_code(inband_code_length_control[f][`ILC_LEN_UP_LSB +: 4]),
                .def1(up_code_definition_1[f]),
                .def2(up_code_definition_2[f]),
                .bit_valid(bit_valid[f]),
                .bit_in(rx_data_q[f]),
                .detected(det_rt[3*f+0]),
                .set_pulse(det_set[3*f+0]),
                .clear_pulse(det_clr[3*f+0])
            );

            ilc_detector #(
                .INTEG_BITS(INTEG_BITS)
            ) u_down (
                .clk(pclk),
                .rstn(presetn),
                .enable(t1_mode_s[f]),
                .restart(det_restart[3*f+1]),
                .len_code(inband_code_length_control[f][`ILC_LEN_DN_LSB +: 4]),
                .def1(down_code_definition_1[f]),
                .def2(down_code_definition_2[f]),
                .bit_valid(bit_valid[f]),
                .bit_in(rx_data_q[f]),
                .detected(det_rt[3*f+1]),
                .set_pulse(det_set[3*f+1]),
                .clear_pulse(det_clr[3*f+1])
            );

            ilc_detector #(
                .INTEG_BITS(INTEG_BITS)
            ) u_spare (
                .clk(pclk),
                .rstn(presetn),
                .enable(t1_mode_s[f]),
                .restart(det_restart[3*f+2]),
                .len_code(spare_code_length_control[f][`ILC_LEN_SP_LSB +: 4]),
                .def1(spare_code_definition_1[f]),
                .def2(spare_code_definition_2[f]),
                .bit_valid(bit_valid[f]),
                .bit_in(rx_data_q[f]),
                .detected(det_rt[3*f+2]),
                .set_pulse(det_set[3*f+2]),
                .clear_pulse(det_clr[3*f+2])
            );
        end
    endgenerate

    // next latched status: write-one clears first, then detector events set,
    // so an event in the clearing cycle is never lost
    always @* begin
        for (i = 0; i < `ILC_FRAMERS; i = i + 1) begin
            next_latched[i] = loop_code_latched_status[i];
            if (wr_en && (sel_framer == i) && (sel_index == `ILC_IDX_LATCHED))
                next_latched[i] = next_latched[i] & ~pwdata[7:0];
            next_latched[i][`ILC_BIT_UP_SET] = next_latched[i][`ILC_BIT_UP_SET] | det_set[3*i+0];
            next_latched[i][`ILC_BIT_DN_SET] = next_latched[i][`ILC_BIT_DN_SET] | det_set[3*i+1];
            next_latched[i][`ILC_BIT_SP_SET] = next_latched[i][`ILC_BIT_SP_SET] | det_set[3*i+2];
            next_latched[i][`ILC_BIT_UP_CLR] = next_latched[i][`ILC_BIT_UP_CLR] | det_clr[3*i+0];
            next_latched[i][`ILC_BIT_DN_CLR] = next_latched[i][`ILC_BIT_DN_CLR] | det_clr[3*i+1];
            next_latched[i][`ILC_BIT_SP_CLR] = next_latched[i][`ILC_BIT_SP_CLR] | det_clr[3*i+2];
        end
    end

    // register file writes; realtime status has no storage so writes cannot touch it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `ILC_FRAMERS; i = i + 1) begin
                inband_code_length_control[i] <= `ILC_RST_LEN_CTL;
                spare_code_length_control[i] <= `ILC_RST_SP_LEN;
                up_code_definition_1[i] <= `ILC_RST_DEF;
                up_code_definition_2[i] <= `ILC_RST_DEF;
                down_code_definition_1[i] <= `ILC_RST_DEF;
                down_code_definition_2[i] <= `ILC_RST_DEF;
                spare_code_definition_1[i] <= `ILC_RST_DEF;
                spare_code_definition_2[i] <= `ILC_RST_DEF;
                loop_code_interrupt_mask[i] <= `ILC_RST_MASK;
                loop_code_latched_status[i] <= `ILC_RST_LATCHED;
            end
        end else begin
            for (i = 0; i < `ILC_FRAMERS; i = i + 1) begin
                loop_code_latched_status[i] <= next_latched[i];
                if (wr_en && (sel_framer == i)) begin
                    case (sel_index)
                        `ILC_IDX_LEN_CTL: inband_code_length_control[i] <= pwdata[7:0];
                        `ILC_IDX_SP_LEN: spare_code_length_control[i] <= pwdata[7:0];
                        `ILC_IDX_UP_DEF1: up_code_definition_1[i] <= pwdata[7:0];
                        `ILC_IDX_UP_DEF2: up_code_definition_2[i] <= pwdata[7:0];
                        `ILC_IDX_DN_DEF1: down_code_definition_1[i] <= pwdata[7:0];
                        `ILC_IDX_DN_DEF2: down_code_definition_2[i] <= pwdata[7:0];
                        `ILC_IDX_SP_DEF1: spare_code_definition_1[i] <= pwdata[7:0];
                        `ILC_IDX_SP_DEF2: spare_code_definition_2[i] <= pwdata[7:0];
                        `ILC_IDX_MASK: loop_code_interrupt_mask[i] <= pwdata[7:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // read mux; unmapped or misaligned reads return zero with pslverr
    always @* begin
        rd_byte = 8'h00;
        case (sel_index)
            `ILC_IDX_LEN_CTL: rd_byte = inband_code_length_control[sel_framer];
            `ILC_IDX_SP_LEN: rd_byte = spare_code_length_control[sel_framer];
            `ILC_IDX_UP_DEF1: rd_byte = up_code_definition_1[sel_framer];
            `ILC_IDX_UP_DEF2: rd_byte = up_code_definition_2[sel_framer];
            `ILC_IDX_DN_DEF1: rd_byte = down_code_definition_1[sel_framer];
            `ILC_IDX_DN_DEF2: rd_byte = down_code_definition_2[sel_framer];
            `ILC_IDX_SP_DEF1: rd_byte = spare_code_definition_1[sel_framer];
            `ILC_IDX_SP_DEF2: rd_byte = spare_code_definition_2[sel_framer];
            `ILC_IDX_MASK: rd_byte = loop_code_interrupt_mask[sel_framer];
            `ILC_IDX_LATCHED: rd_byte = loop_code_latched_status[sel_framer];
            `ILC_IDX_REALTIME: rd_byte = {5'h00, det_rt[3*sel_framer +: 3]};
            default: rd_byte = 8'h00;
        endcase
        if (!addr_ok)
            rd_byte = 8'h00;
    end

    // read data captured in the setup cycle so it is stable for the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h00_0000, rd_byte};
    end

    // masked interrupt
    // registered so the interrupt output never glitches on decode changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_code_irq <= 4'h0;
        end else begin
            for (i = 0; i < `ILC_FRAMERS; i = i + 1)
                loop_code_irq[i] <= |(loop_code_latched_status[i] & loop_code_interrupt_mask[i]);
        end
    end

endmodule

// *** src/ilc_defines.vh ***
`ifndef ILC_DEFINES_VH
`define ILC_DEFINES_VH

// register indices within one framer (byte address is four times the index)
`define ILC_IDX_LEN_CTL 9'h082
`define ILC_IDX_LATCHED 9'h092
`define ILC_IDX_SP_DEF1 9'h09c
`define ILC_IDX_SP_DEF2 9'h09d
`define ILC_IDX_SP_LEN 9'h09e
`define ILC_IDX_MASK 9'h0a2
`define ILC_IDX_UP_DEF1 9'h0ac
`define ILC_IDX_UP_DEF2 9'h0ad
`define ILC_IDX_DN_DEF1 9'h0ae
`define ILC_IDX_DN_DEF2 9'h0af
`define ILC_IDX_REALTIME 9'h0b2

// framer replication: framer n sits at framer 1 index plus (n - 1) times this stride
`define ILC_FRAMER_STRIDE 12'h200
`define ILC_FRAMERS 4

// length control fields: up code in the low nibble, down code in the high nibble
`define ILC_LEN_UP_LSB 0
`define ILC_LEN_DN_LSB 4
`define ILC_LEN_SP_LSB 0
// length codes 0..7 select 1..8 bits, any code of 8 or more selects 16 bits
`define ILC_LEN_CODE_16 4'h8

// status bit positions (realtime uses the set positions only)
`define ILC_BIT_UP_SET 0
`define ILC_BIT_DN_SET 1
`define ILC_BIT_SP_SET 2
`define ILC_BIT_UP_CLR 4
`define ILC_BIT_DN_CLR 5
`define ILC_BIT_SP_CLR 6

// reset values
`define ILC_RST_LEN_CTL 8'h00
`define ILC_RST_SP_LEN 8'h00
`define ILC_RST_DEF 8'h00
`define ILC_RST_MASK 8'h00
`define ILC_RST_LATCHED 8'h00

// integration period in line bits: 48 ms at the 1544 kbit/s line rate
`define ILC_INTEG_MS 48
`define ILC_LINE_KBPS 1544
// tolerated errors per period are the period shifted right by this amount (about 3 %)
`define ILC_ERR_SHIFT 5

`endif

// *** src/ilc_sync.v ***
// two-stage synchroniser for pin inputs; stage one feeds stage two only
module ilc_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // asynchronous in, synchronous out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta;

    // plain double flop, no logic between the stages
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// *** src/ilc_detector.v ***
`include "ilc_defines.vh"

// one repeating-pattern detector with error-tolerant integration
module ilc_detector #(
    parameter [16:0] INTEG_BITS = 17'd74112
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire enable,
    input wire restart,
    input wire [3:0] len_code,
    input wire [7:0] def1,
    input wire [7:0] def2,
    // received line bits
    input wire bit_valid,
    input wire bit_in,
    // status
    output reg detected,
    output reg set_pulse,
    output reg clear_pulse
);

    localparam [16:0] ERR_LIMIT = INTEG_BITS >> `ILC_ERR_SHIFT;

    reg [3:0] phase;
    reg [2:0] since_miss;
    reg [16:0] bit_cnt;
    reg [16:0] err_cnt;

    // short codes first byte
    // pattern bit at a phase, sent msb first; short codes use only the first byte
    function pattern_bit;
        input [7:0] b1;
        input [7:0] b2;
        input is16;
        input [3:0] p;
        reg [15:0] w;
        begin
            w = {b1, b2};
            if (is16)
                pattern_bit = w[4'hf - p];
            else
                pattern_bit = b1[3'h7 - p[2:0]];
        end
    endfunction

    // phase step by one or two positions, wrapping at the code length
    function [3:0] phase_step;
        input [3:0] p;
        input [4:0] len;
        input two;
        reg [4:0] s;
        begin
            s = {1'b0, p} + (two ? 5'd2 : 5'd1);
            if (s >= len)
                s = s - len;
            if (s >= len)
                s = 5'd0;
            phase_step = s[3:0];
        end
    endfunction

    wire is16 = (len_code >= `ILC_LEN_CODE_16);
    wire [4:0] len = is16 ? 5'd16 : {2'b00, len_code[2:0]} + 5'd1;
    wire expected = pattern_bit(def1, def2, is16, phase);
    wire miss = bit_in ^ expected;
    wire last_bit = (bit_cnt == INTEG_BITS - 17'd1);
    wire [16:0] err_total = err_cnt + {16'd0, miss};
    // a miss within four bits of the last one means lost alignment; a lone miss never slips
    wire slip = miss && (since_miss < 3'd4);

    // phase tracking, error counting and the decision at the end of each period
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 4'h0;
            since_miss <= 3'd7;
            bit_cnt <= 17'd0;
            err_cnt <= 17'd0;
            detected <= 1'b0;
            set_pulse <= 1'b0;
            clear_pulse <= 1'b0;
        end else begin
            set_pulse <= 1'b0;
            clear_pulse <= 1'b0;
            if (!enable) begin
                phase <= 4'h0;
                since_miss <= 3'd7;
                bit_cnt <= 17'd0;
                err_cnt <= 17'd0;
                detected <= 1'b0;
            end else if (restart) begin
                phase <= 4'h0;
                since_miss <= 3'd7;
                bit_cnt <= 17'd0;
                err_cnt <= 17'd0;
            end else if (bit_valid) begin
                // slip on burst
                // close misses mean lost alignment (inserted f-bit or start-up): hold the phase
                // one bit to hunt; a lone miss is a line error or an overwritten f-bit, only counted
                phase <= slip ? phase : phase_step(phase, len, 1'b0);
                since_miss <= slip ? 3'd7 : (miss ? 3'd0 : since_miss + {2'b00, since_miss != 3'd7});
                if (last_bit) begin
                    bit_cnt <= 17'd0;
                    err_cnt <= 17'd0;
                    if (err_total <= ERR_LIMIT) begin
                        if (!detected)
                            set_pulse <= 1'b1;
                        detected <= 1'b1;
                    end else begin
                        if (detected)
                            clear_pulse <= 1'b1;
                        detected <= 1'b0;
                    end
                end else begin
                    bit_cnt <= bit_cnt + 17'd1;
                    err_cnt <= err_total;
                end
            end
        end
    end

endmodule

// *** verification/ilc_props.sv ***
`include "ilc_defines.vh"

// protocol and interrupt checks seen from the top ports only
module ilc_props #(
    parameter [16:0] INTEG_BITS = 17'd200
) (
    // clock and reset
    input logic pclk,
    input logic presetn,
    // apb side
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [13:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    // interrupt contributions
    input logic [3:0] loop_code_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_always: assert property (pready)
        else $error("pready low");
    a_rdata_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access without error");
    a_high_addr_err: assert property (psel && penable && paddr[13] |-> pslverr)
        else $error("out of range access without error");
    a_idle_no_err: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    // read data only moves after a read setup cycle
    a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata moved without read setup");
    a_err_read_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    // a cleared mask silences that framer two cycles later
    a_mask_off_irq: assert property (psel && penable && pwrite && !paddr[13] && paddr[1:0] == 2'b00
        && paddr[10:2] == `ILC_IDX_MASK && pwdata[7:0] == 8'h00
        |=> ##1 !loop_code_irq[$past(paddr[12:11], 2)])
        else $error("irq with mask cleared");
endmodule

// *** verification/ilc_line_src.sv ***
// receive line model: repeating code, framing slot every 193 bits, sparse bit errors
module ilc_line_src (
    // clock and reset
    input logic clk,
    input logic rstn,
    // code to send, left aligned, and framing mode
    input logic [15:0] pat,
    input logic [4:0] plen,
    input logic [1:0] fmode,
    // line pins for all four framers
    output logic [3:0] rx_data,
    output logic [3:0] rx_bit_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph;
    logic [4:0] idx;
    logic [7:0] fcnt;
    logic [6:0] ecnt;
    logic b;

    // strobe high and low four cycles each; data moves one cycle before the rise
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph <= 3'h0;
            idx <= 5'h0;
            fcnt <= 8'h0;
            ecnt <= 7'h0;
            rx_data <= 4'h0;
            rx_bit_strobe <= 4'h0;
        end else begin
            ph <= ph + 3'h1;
            rx_bit_strobe <= {4{ph[2]}};
            if (ph == 3'h3) begin
                fcnt <= (fcnt == 8'd192) ? 8'h0 : fcnt + 8'h1;
                ecnt <= ecnt + 7'h1;
                if (fcnt == 8'd192 && fmode == 2'd1) begin
                    b = 1'b1;
                end else begin
                    b = pat[5'd15 - idx];
                    idx <= (idx + 5'h1 >= plen) ? 5'h0 : idx + 5'h1;
                    if (fcnt == 8'd192 && fmode == 2'd2)
                        b = ~b;
                end
                // one error in 128 bits, inside the tolerated rate
                if (fmode != 2'd0 && ecnt == 7'h0)
                    b = ~b;
                rx_data <= {4{b}};
            end
        end
    end
endmodule

// *** verification/testbench.sv ***
`include "ilc_defines.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [16:0] IB = 17'd200;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [3:0] t1_mode = 4'h0;
    logic [15:0] pat = 16'hffff;
    logic [4:0] plen = 5'd16;
    logic [1:0] fmode = 2'd0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [3:0] rx_data, rx_bit_strobe, loop_code_irq;
    int n_errors = 0, tests_run = 0, seed = 91668, fr;
    logic [8:0] ri[11] = '{`ILC_IDX_LEN_CTL, `ILC_IDX_UP_DEF1, `ILC_IDX_UP_DEF2, `ILC_IDX_DN_DEF1,
        `ILC_IDX_DN_DEF2, `ILC_IDX_SP_DEF1, `ILC_IDX_SP_DEF2, `ILC_IDX_LATCHED, `ILC_IDX_MASK,
        `ILC_IDX_REALTIME, `ILC_IDX_SP_LEN};
    logic [15:0] pt[3] = '{16'ha5c3, 16'h3e3e, 16'h8800};
    logic [4:0] pl[3] = '{5'd16, 5'd8, 5'd5};
    logic [7:0] d8;

    always #2 pclk = ~pclk;

    ilc_top #(.INTEG_BITS(IB)) u_ilc_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_data(rx_data), .rx_bit_strobe(rx_bit_strobe), .t1_mode(t1_mode), .loop_code_irq(loop_code_irq));
    ilc_line_src u_ilc_line_src(.clk(pclk), .rstn(presetn), .pat(pat), .plen(plen), .fmode(fmode),
        .rx_data(rx_data), .rx_bit_strobe(rx_bit_strobe));

    function automatic logic [13:0] ad(input int f, input logic [8:0] idx);
        ad = {1'b0, f[1:0], idx, 2'b00};
    endfunction

    // one apb transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input int f, input logic [8:0] i, input logic [7:0] d);
        apb(1'b1, ad(f, i), {24'h0, d});
    endtask

    task automatic rchk(input int f, input logic [8:0] i, input logic [7:0] exp);
        apb(1'b0, ad(f, i), 32'h0);
        chk(r, {24'h0, exp});
    endtask

    // periodic status polling
    // poll the realtime bit with a bounded number of reads
    task automatic wait_rt(input int f, input int bn, input logic v);
        repeat (80) begin
            repeat (150) @(posedge pclk);
            apb(1'b0, ad(f, `ILC_IDX_REALTIME), 32'h0);
            if (r[bn] === v)
                break;
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog sized well above the longest detection sequence
    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t1_mode <= 4'hf;
        foreach (ri[i]) rchk(0, ri[i], 8'h00);
        wr(1, `ILC_IDX_REALTIME, 8'hff);
        rchk(1, `ILC_IDX_REALTIME, 8'h00);
        repeat (12) begin
            fr = $random(seed) & 3;
            d8 = $random(seed);
            fr = fr + 4 * (($random(seed) & 32'h7fffffff) % 7);
            wr(fr % 4, ri[fr / 4], d8);
            rchk(fr % 4, ri[fr / 4], d8);
        end
        // refused accesses: unmapped, misaligned, beyond the framers
        apb(1'b0, 14'h0000, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        apb(1'b1, ad(2, `ILC_IDX_MASK) + 14'h1, 32'hff);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, ad(0, `ILC_IDX_LEN_CTL) | 14'h2000, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int d = 0; d < 3; d++) begin
            fr = $random(seed) & 3;
            t1_mode <= 4'($random(seed)) | (4'h1 << fr);
            wr(fr, `ILC_IDX_LEN_CTL, 8'h78);
            wr(fr, `ILC_IDX_SP_LEN, 8'h04);
            wr(fr, `ILC_IDX_UP_DEF2, 8'hc3);
            wr(fr, `ILC_IDX_UP_DEF1, 8'ha5);
            wr(fr, `ILC_IDX_DN_DEF2, 8'h3e);
            wr(fr, `ILC_IDX_DN_DEF1, 8'h3e);
            wr(fr, `ILC_IDX_SP_DEF2, 8'($random(seed)));
            wr(fr, `ILC_IDX_SP_DEF1, 8'h88);
            wr(fr, `ILC_IDX_LATCHED, 8'h77);
            pat <= pt[d];
            plen <= pl[d];
            fmode <= 2'(d);
            wait_rt(fr, d, 1'b1);
            rchk(fr, `ILC_IDX_REALTIME, 8'h01 << d);
            rchk(fr, `ILC_IDX_LATCHED, 8'h01 << d);
            wr(fr, `ILC_IDX_MASK, 8'h01 << d);
            repeat (4) @(posedge pclk);
            chk({31'h0, loop_code_irq[fr]}, 32'h1);
            wr(fr, `ILC_IDX_MASK, 8'h77 ^ (8'h01 << d));
            repeat (4) @(posedge pclk);
            chk({31'h0, loop_code_irq[fr]}, 32'h0);
            wr(fr, `ILC_IDX_MASK, 8'h00);
            wr(fr, `ILC_IDX_LATCHED, 8'h00);
            rchk(fr, `ILC_IDX_LATCHED, 8'h01 << d);
            wr(fr, `ILC_IDX_LATCHED, 8'h01 << d);
            rchk(fr, `ILC_IDX_LATCHED, 8'h00);
            if (d == 2) begin
                t1_mode[fr] <= 1'b0;
                repeat (10) @(posedge pclk);
                rchk(fr, `ILC_IDX_REALTIME, 8'h00);
                rchk(fr, `ILC_IDX_LATCHED, 8'h00);
            end else begin
                pat <= 16'hffff;
                plen <= 5'd16;
                fmode <= 2'd0;
                wait_rt(fr, d, 1'b0);
                rchk(fr, `ILC_IDX_REALTIME, 8'h00);
                rchk(fr, `ILC_IDX_LATCHED, 8'h10 << d);
                wr(fr, `ILC_IDX_LATCHED, 8'h77);
            end
        end
        wrap_up;
    end
endmodule

bind ilc_top ilc_props #(.INTEG_BITS(INTEG_BITS)) u_ilc_props(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_code_irq(loop_code_irq));
